// >>> shared/pmbh_pkg.sv
// pmbh_pkg: constants shared by the power bus host controller files
package pmbh_pkg;
   // clock and serial bus timing
   localparam int CLK_NS = 40;
   localparam int SCL_SLOW_NS = 10000;
   localparam int SCL_FAST_NS = 2500;
   localparam logic [7:0] Q_SLOW =
      8'((SCL_SLOW_NS / 4 + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] Q_FAST =
      8'((SCL_FAST_NS / 4 + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] Q_ONE = 8'h01;
   // pacing and lock-up times
   localparam longint NS_PER_S = 64'd1000000000;
   localparam longint NS_PER_MS = 64'd1000000;
   localparam int ALERT_WAIT_S = 2;
   localparam int READ_GAP_S = 1;
   localparam int LOCKUP_MS = 35;
   localparam logic [25:0] ALERT_WAIT_CYC =
      26'((ALERT_WAIT_S * NS_PER_S + CLK_NS - 1) / CLK_NS);
   localparam logic [25:0] READ_GAP_CYC =
      26'((READ_GAP_S * NS_PER_S + CLK_NS - 1) / CLK_NS);
   localparam logic [19:0] LOCKUP_CYC =
      20'((LOCKUP_MS * NS_PER_MS + CLK_NS - 1) / CLK_NS);
   // framing
   localparam logic [3:0] ADDR_HI = 4'hb;
   localparam logic [7:0] CRC_POLY = 8'h07;
   localparam logic [7:0] CRC_INIT = 8'h00;
   localparam logic [1:0] NB_MAX = 2'h2;
   localparam logic [1:0] NB_MIN_RD = 2'h1;
   localparam logic [2:0] IDX_CMD = 3'h1;
   localparam logic [2:0] WR_LAST_BASE = 3'h1;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;
   // quarter phases of one bit
   localparam logic [1:0] PH_LOW = 2'h0;
   localparam logic [1:0] PH_RISE = 2'h1;
   localparam logic [1:0] PH_HIGH = 2'h2;
   localparam logic [1:0] PH_FALL = 2'h3;
   // synchronised pin vector
   localparam logic [4:0] PINS_IDLE = 5'h1f;
   localparam int P_SCL = 0;
   localparam int P_SDA = 1;
   localparam int P_ALERT = 2;
   localparam int P_FAULT = 4;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_WAIT = 3'b001,
      ST_START = 3'b010,
      ST_TX = 3'b011,
      ST_RX = 3'b100,
      ST_STOP = 3'b101
   } pmbh_state_t;
endpackage

// >>> src/pmbh_crc8.sv
// pmbh_crc8: running packet error check over whole bytes
`timescale 1ns/10ps
module pmbh_crc8 (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // byte stream
   input wire logic clr_in,
   input wire logic en_in,
   input wire logic [7:0] data_in,
   // running value
   output logic [7:0] crc_out
);
   // one byte through the polynomial, msb first
   function automatic logic [7:0] crc_step(input logic [7:0] c,
                                           input logic [7:0] d);
      logic [7:0] r;
      r = c ^ d;
      for (int i = 0; i < 8; i++) begin
         r = r[7] ? ((r << 1) ^ pmbh_pkg::CRC_POLY) : (r << 1);
      end
      return r;
   endfunction

   // clear wins so a new frame never inherits old bytes
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         crc_out <= pmbh_pkg::CRC_INIT;
      end else if (clr_in) begin
         crc_out <= pmbh_pkg::CRC_INIT;
      end else if (en_in) begin
         crc_out <= crc_step(crc_out, data_in);
      end
   end
endmodule

// >>> src/pmbh_host.sv
// pmbh_host: bus master for a power supply management slave
`timescale 1ns/10ps
module pmbh_host #(
   parameter logic [25:0] ALERT_WAIT_CYC = pmbh_pkg::ALERT_WAIT_CYC,
   parameter logic [25:0] READ_GAP_CYC = pmbh_pkg::READ_GAP_CYC,
   parameter logic [19:0] LOCKUP_CYC = pmbh_pkg::LOCKUP_CYC
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // user command
   input wire logic cmd_valid_in,
   input wire logic cmd_read_in,
   input wire logic cmd_fast_in,
   input wire logic cmd_pec_in,
   input wire logic [1:0] cmd_nbytes_in,
   input wire logic [2:0] addr_strap_in,
   input wire logic [7:0] cmd_code_in,
   input wire logic [15:0] cmd_wdata_in,
   output logic cmd_ready_out,
   // user result
   output logic done_out,
   output logic [15:0] rd_data_out,
   output logic nack_out,
   output logic pec_err_out,
   output logic timeout_out,
   // serial bus pins
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe_out,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   // supply status pins, active low at the pin
   input wire logic alert_n_in,
   input wire logic ot_warn_n_in,
   input wire logic fault_n_in,
   output logic alert_out,
   output logic ot_warn_out,
   output logic fault_out
);
   pmbh_pkg::pmbh_state_t st_q;
   logic [4:0] s1_q, s2_q, s3_q, pin_q;
   logic [2:0] stat_q;
   logic alert_d_q;
   logic [25:0] hold_q;
   logic [19:0] lk_q;
   logic [7:0] qcnt_q, qload, crc_val, tx_next;
   logic [1:0] ph_q, n_q;
   logic [3:0] bit_q;
   logic [2:0] idx_q, addr_q, wlast, rlast;
   logic [7:0] byte_q, code_q;
   logic [15:0] wdat_q;
   logic rd_q, fast_q, pec_q, ack_q, rsd_q;
   logic crc_en_q, crc_clr_q;
   logic active, tick, lock_hit;

   // pins from outside pass three flops; a change counts once 2nd and 3rd
   // agree, so one glitchy sample never toggles the bit engine
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s1_q <= pmbh_pkg::PINS_IDLE;
         s2_q <= pmbh_pkg::PINS_IDLE;
         s3_q <= pmbh_pkg::PINS_IDLE;
         pin_q <= pmbh_pkg::PINS_IDLE;
      end else begin
         s1_q <= {fault_n_in, ot_warn_n_in, alert_n_in, sda_in, scl_in};
         s2_q <= s1_q;
         s3_q <= s2_q;
         pin_q <= (s2_q & s3_q) | (pin_q & (s2_q | s3_q));
      end
   end

   // status flags are reported unlatched, and the alert edge also starts read pacing; alert latching lives in the device
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stat_q <= '0;
         alert_d_q <= 1'b1;
      end else begin
         stat_q <= ~pin_q[pmbh_pkg::P_FAULT:pmbh_pkg::P_ALERT];
         alert_d_q <= pin_q[pmbh_pkg::P_ALERT];
      end
   end
   assign {fault_out, ot_warn_out, alert_out} = stat_q;

   // read pacing: settle after an alert, space read-backs
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         hold_q <= '0;
      end else if (alert_d_q && !pin_q[pmbh_pkg::P_ALERT]) begin
         hold_q <= ALERT_WAIT_CYC;
      end else if (done_out && rd_q && hold_q < READ_GAP_CYC) begin
         hold_q <= READ_GAP_CYC;
      end else if (hold_q != '0) begin
         hold_q <= hold_q - 26'h1;
      end
   end

   assign active = st_q inside {pmbh_pkg::ST_START, pmbh_pkg::ST_TX,
                                pmbh_pkg::ST_RX, pmbh_pkg::ST_STOP};
   // high quarter waits for the line to really rise
   assign tick = (qcnt_q == '0) &&
                 (ph_q != pmbh_pkg::PH_HIGH || pin_q[pmbh_pkg::P_SCL]);
   assign qload = (fast_q ? pmbh_pkg::Q_FAST : pmbh_pkg::Q_SLOW)
                  - pmbh_pkg::Q_ONE;
   assign lock_hit = lk_q >= LOCKUP_CYC;
   assign wlast = pmbh_pkg::WR_LAST_BASE + {1'b0, n_q} + {2'b0, pec_q};
   assign rlast = 3'({1'b0, n_q} + {2'b0, pec_q} - 3'h1);

   // quarter-bit timer
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         qcnt_q <= pmbh_pkg::Q_SLOW;
      end else if (!active || tick) begin
         qcnt_q <= qload;
      end else if (qcnt_q != '0) begin
         qcnt_q <= qcnt_q - pmbh_pkg::Q_ONE;
      end
   end

   // low-line watchdog; a stretch is honoured only up to the lock-up time
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         lk_q <= '0;
      end else if (active && !scl_oe_out && !pin_q[pmbh_pkg::P_SCL]) begin
         lk_q <= lk_q + 20'h1;
      end else begin
         lk_q <= '0;
      end
   end

   // next outgoing byte of a write, index of the byte just sent
   always_comb begin
      unique case (idx_q)
         3'h0: tx_next = code_q;
         3'h1: tx_next = (n_q != '0) ? wdat_q[7:0] : crc_val;
         3'h2: tx_next = (n_q == pmbh_pkg::NB_MAX) ? wdat_q[15:8] : crc_val;
         default: tx_next = crc_val;
      endcase
   end

   pmbh_crc8 u_crc (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .clr_in(crc_clr_q),
      .en_in(crc_en_q),
      .data_in(byte_q),
      .crc_out(crc_val)
   );

   // frame sequencer and bit engine; the host alone makes clocks
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_q <= pmbh_pkg::ST_IDLE;
         ph_q <= pmbh_pkg::PH_LOW;
         bit_q <= '0;
         idx_q <= '0;
         byte_q <= '0;
         ack_q <= 1'b0;
         rsd_q <= 1'b0;
         {rd_q, fast_q, pec_q} <= '0;
         n_q <= '0;
         addr_q <= '0;
         code_q <= '0;
         wdat_q <= '0;
         scl_oe_out <= 1'b0;
         sda_oe_out <= 1'b0;
         scl_out <= 1'b0;
         sda_out <= 1'b0;
         cmd_ready_out <= 1'b1;
         done_out <= 1'b0;
         rd_data_out <= '0;
         {nack_out, pec_err_out, timeout_out} <= '0;
         crc_en_q <= 1'b0;
         crc_clr_q <= 1'b0;
      end else begin
         done_out <= 1'b0;
         crc_en_q <= 1'b0;
         crc_clr_q <= 1'b0;
         if (active && tick) begin
            ph_q <= ph_q + 2'h1;
         end
         if (active && lock_hit) begin
            // give the bus back and report
            scl_oe_out <= 1'b0;
            sda_oe_out <= 1'b0;
            st_q <= pmbh_pkg::ST_IDLE;
            timeout_out <= 1'b1;
            done_out <= 1'b1;
            cmd_ready_out <= 1'b1;
         end else begin
            unique case (st_q)
               pmbh_pkg::ST_IDLE: if (cmd_valid_in) begin
                  rd_q <= cmd_read_in;
                  fast_q <= cmd_fast_in;
                  pec_q <= cmd_pec_in;
                  // two data bytes at most on this framing
                  if (cmd_nbytes_in > pmbh_pkg::NB_MAX) begin
                     n_q <= pmbh_pkg::NB_MAX;
                  end else if (cmd_read_in && cmd_nbytes_in == '0) begin
                     n_q <= pmbh_pkg::NB_MIN_RD;
                  end else begin
                     n_q <= cmd_nbytes_in;
                  end
                  addr_q <= addr_strap_in;
                  code_q <= cmd_code_in;
                  wdat_q <= cmd_wdata_in;
                  {nack_out, pec_err_out, timeout_out} <= '0;
                  cmd_ready_out <= 1'b0;
                  st_q <= pmbh_pkg::ST_WAIT;
               end
               pmbh_pkg::ST_WAIT: if (!rd_q || hold_q == '0) begin
                  st_q <= pmbh_pkg::ST_START;
                  ph_q <= pmbh_pkg::PH_LOW;
                  rsd_q <= 1'b0;
                  idx_q <= '0;
                  crc_clr_q <= 1'b1;
               end
               pmbh_pkg::ST_START: if (tick) begin
                  unique case (ph_q)
                     pmbh_pkg::PH_LOW: sda_oe_out <= 1'b0;
                     pmbh_pkg::PH_RISE: scl_oe_out <= 1'b0;
                     pmbh_pkg::PH_HIGH: sda_oe_out <= 1'b1;
                     pmbh_pkg::PH_FALL: begin
                        scl_oe_out <= 1'b1;
                        st_q <= pmbh_pkg::ST_TX;
                        bit_q <= '0;
                        byte_q <= {pmbh_pkg::ADDR_HI, addr_q, rsd_q};
                     end
                  endcase
               end
               pmbh_pkg::ST_TX, pmbh_pkg::ST_RX: if (tick) begin
                  unique case (ph_q)
                     pmbh_pkg::PH_LOW: begin
                        if (st_q == pmbh_pkg::ST_RX) begin
                           // ack all but the last byte
                           sda_oe_out <= (bit_q == pmbh_pkg::BIT_ACK) &&
                                         (idx_q != rlast);
                        end else begin
                           sda_oe_out <= (bit_q != pmbh_pkg::BIT_ACK) &&
                              !byte_q[3'(pmbh_pkg::BIT_LAST - bit_q)];
                        end
                     end
                     pmbh_pkg::PH_RISE: scl_oe_out <= 1'b0;
                     pmbh_pkg::PH_HIGH: begin
                        if (bit_q == pmbh_pkg::BIT_ACK) begin
                           ack_q <= !pin_q[pmbh_pkg::P_SDA];
                        end else if (st_q == pmbh_pkg::ST_RX) begin
                           byte_q <= {byte_q[6:0], pin_q[pmbh_pkg::P_SDA]};
                        end
                     end
                     pmbh_pkg::PH_FALL: begin
                        scl_oe_out <= 1'b1;
                        if (bit_q != pmbh_pkg::BIT_ACK) begin
                           bit_q <= bit_q + 4'h1;
                        end else begin
                           bit_q <= '0;
                        end
                        if (bit_q == pmbh_pkg::BIT_LAST) begin
                           // whole byte seen: fold into check or compare
                           if (st_q == pmbh_pkg::ST_TX) begin
                              crc_en_q <= 1'b1;
                           end else if (idx_q < {1'b0, n_q}) begin
                              crc_en_q <= 1'b1;
                              if (idx_q == '0) begin
                                 rd_data_out[7:0] <= byte_q;
                              end else begin
                                 rd_data_out[15:8] <= byte_q;
                              end
                           end else begin
                              pec_err_out <= byte_q != crc_val;
                           end
                        end
                        if (bit_q == pmbh_pkg::BIT_ACK) begin
                           if (st_q == pmbh_pkg::ST_RX) begin
                              if (idx_q == rlast) begin
                                 st_q <= pmbh_pkg::ST_STOP;
                              end else begin
                                 idx_q <= idx_q + 3'h1;
                              end
                           end else if (!ack_q) begin
                              st_q <= pmbh_pkg::ST_STOP;
                              nack_out <= 1'b1;
                           end else if (rd_q && !rsd_q &&
                                        idx_q == pmbh_pkg::IDX_CMD) begin
                              st_q <= pmbh_pkg::ST_START;
                              rsd_q <= 1'b1;
                           end else if (rd_q && rsd_q) begin
                              st_q <= pmbh_pkg::ST_RX;
                              idx_q <= '0;
                           end else if (idx_q < wlast) begin
                              idx_q <= idx_q + 3'h1;
                              byte_q <= tx_next;
                           end else begin
                              st_q <= pmbh_pkg::ST_STOP;
                           end
                        end
                     end
                  endcase
               end
               pmbh_pkg::ST_STOP: if (tick) begin
                  unique case (ph_q)
                     pmbh_pkg::PH_LOW: sda_oe_out <= 1'b1;
                     pmbh_pkg::PH_RISE: scl_oe_out <= 1'b0;
                     pmbh_pkg::PH_HIGH: sda_oe_out <= 1'b0;
                     pmbh_pkg::PH_FALL: begin
                        st_q <= pmbh_pkg::ST_IDLE;
                        done_out <= 1'b1;
                        cmd_ready_out <= 1'b1;
                     end
                  endcase
               end
               default: st_q <= pmbh_pkg::ST_IDLE;
            endcase
         end
      end
   end

   // checks run on the system clock and rest during reset
   default clocking a_cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);

   a_stretch_hold: assert property (
      (active && ph_q == pmbh_pkg::PH_HIGH && !pin_q[pmbh_pkg::P_SCL]
       && !lock_hit) |=> (ph_q == pmbh_pkg::PH_HIGH && !scl_oe_out))
      else $error("clock pulse issued during a stretch");
   a_rate_reload: assert property (
      (active && tick && !fast_q) |=> qcnt_q == pmbh_pkg::Q_SLOW - 8'h1)
      else $error("slow rate quarter wrong");
   a_read_pace: assert property (
      (st_q == pmbh_pkg::ST_WAIT && rd_q && hold_q != '0)
      |=> st_q != pmbh_pkg::ST_START)
      else $error("read started before pacing expired");
   a_crc_fresh: assert property (
      (st_q == pmbh_pkg::ST_START && $past(st_q) == pmbh_pkg::ST_WAIT)
      |=> crc_val == pmbh_pkg::CRC_INIT)
      else $error("check not cleared at frame start");
   a_pec_append: assert property (
      (st_q == pmbh_pkg::ST_TX && tick && ph_q == pmbh_pkg::PH_FALL
       && bit_q == pmbh_pkg::BIT_ACK && ack_q && !rd_q && pec_q
       && 3'(idx_q + 3'h1) == wlast) |=> byte_q == crc_val)
      else $error("write check byte wrong");
   a_nack_last: assert property (
      (st_q == pmbh_pkg::ST_RX && bit_q == pmbh_pkg::BIT_ACK
       && idx_q == rlast && ph_q == pmbh_pkg::PH_HIGH) |-> !sda_oe_out)
      else $error("last read byte acknowledged");
   a_byte_cap: assert property (
      st_q != pmbh_pkg::ST_IDLE |-> n_q <= pmbh_pkg::NB_MAX)
      else $error("more than two data bytes");
   a_addr_frame: assert property (
      (st_q == pmbh_pkg::ST_TX && $past(st_q) == pmbh_pkg::ST_START)
      |-> (byte_q[7:4] == pmbh_pkg::ADDR_HI && byte_q[0] == rsd_q))
      else $error("address byte malformed");
   a_abort_free: assert property (
      (active && lock_hit) |=> (!scl_oe_out && !sda_oe_out && timeout_out))
      else $error("bus not released on lock-up");
endmodule

// >>> testbench/pmbh_dev_model.sv
// pmbh_dev_model: behavioural power supply slave on the serial bus
`timescale 1ns/10ps
module pmbh_dev_model #(
   parameter logic [2:0] STRAP = 3'h5,
   parameter logic [7:0] UNSUP = 8'hee
) (
   // wired bus levels in, pull enables out
   input wire logic scl_in,
   input wire logic sda_in,
   output logic scl_oe_out,
   output logic sda_oe_out,
   // bench controls
   input wire logic [15:0] rd_val_in,
   input wire logic bad_pec_in,
   input wire logic [19:0] stretch_ns_in,
   input wire logic alarm_in,
   input wire logic ot_in,
   input wire logic fault_in,
   // status pins and captured write
   output logic alert_n_out,
   output logic ot_warn_n_out,
   output logic fault_n_out,
   output logic [7:0] cmd_out,
   output logic [15:0] wdata_out,
   output logic pec_ok_out,
   output logic [2:0] nbytes_out
);
   int bitn = 9;
   int byten = 0;
   logic rd = 1'h0, tx = 1'h0, match = 1'h0, alert_q = 1'h0;
   logic [7:0] sh = 8'h00, crc = 8'h00, txb = 8'h00, hi = 8'h00;
   function automatic logic [7:0] crc8(input logic [7:0] c, d);
      logic [7:0] x;
      x = c ^ d;
      for (int i = 0; i < 8; i++)
         x = x[7] ? ((x << 1) ^ 8'h07) : (x << 1);
      return x;
   endfunction
   // warning and fault pins follow the supply state directly; alert follows the latched alert_q
   assign ot_warn_n_out = !ot_in;
   assign fault_n_out = !fault_in;
   assign alert_n_out = !alert_q;
   initial begin
      scl_oe_out = 1'h0;
      sda_oe_out = 1'h0;
      {cmd_out, wdata_out, pec_ok_out, nbytes_out} = '0;
   end
   // a new alarm latches the alert low
   always @(posedge alarm_in) alert_q = 1'h1;
   // start; the check runs on only across a restart after the command
   always @(negedge sda_in) if (scl_in) begin
      if (byten != 2 || rd) crc = 8'h00;
      byten = 0;
      bitn = 9;
      tx = 1'h0;
   end
   // stop; clear command drops alert unless the alarm persists
   always @(posedge sda_in) if (scl_in) begin
      if (match && !rd && cmd_out == 8'h03) alert_q = alarm_in;
      byten = 0;
      rd = 1'h0;
      tx = 1'h0;
   end
   // sample on the rising clock
   always @(posedge scl_in) begin
      if (bitn < 8) sh = {sh[6:0], sda_in};
      if (bitn == 7 && !tx) begin
         pec_ok_out = (sh == crc);
         crc = crc8(crc, sh);
         if (byten == 0) begin
            match = (sh[7:1] == {4'hb, STRAP});
            rd = sh[0];
            // broadcast read is refused and raises the alert
            if (sh == 8'h01) alert_q = 1'h1;
         end
         else if (byten == 1) begin
            cmd_out = sh;
            // unsupported command is flagged on the alert line
            if (sh == UNSUP) alert_q = 1'h1;
         end
         else if (byten == 2) wdata_out[7:0] = sh;
         else if (byten == 3) wdata_out[15:8] = sh;
         byten++;
         nbytes_out = 3'(byten);
      end
      else if (bitn == 7) crc = crc8(crc, txb);
      if (bitn == 8 && tx) begin
         tx = !sda_in; // host no-ack ends the data
         txb = (byten == 1) ? hi : (bad_pec_in ? ~crc : crc);
         byten++;
      end
   end
   // drive on the falling clock only, never make clock pulses
   always @(negedge scl_in) begin
      if (bitn == 9) bitn = 0;
      else if (bitn == 8) begin
         bitn = 0;
         sda_oe_out = 1'h0;
         if (match && rd && byten == 1 && !tx) begin
            tx = 1'h1;
            txb = (cmd_out == UNSUP) ? 8'h00 : rd_val_in[7:0];
            hi = (cmd_out == UNSUP) ? 8'h00 : rd_val_in[15:8];
         end
         // stretch only once the ack bit is over
         if (stretch_ns_in != 20'h0) begin
            scl_oe_out = 1'h1;
            #(stretch_ns_in);
            scl_oe_out = 1'h0;
         end
      end
      else begin
         bitn++;
         if (bitn == 8) sda_oe_out = !tx && match;
      end
      if (tx && bitn < 8) sda_oe_out = !txb[7 - bitn];
   end
endmodule

// >>> testbench/tb_top.sv
// tb_top: bench for the power bus host controller against a slave model
`timescale 1ns/10ps
module tb_top;
   localparam int P_SLOW = 4 * 40 * int'(pmbh_pkg::Q_SLOW);
   localparam int P_FAST = 4 * 40 * int'(pmbh_pkg::Q_FAST);
   logic clk_in = 1'h0, rst_n_in = 1'h0, cmd_valid_in = 1'h0;
   logic cmd_read_in = 1'h0, cmd_fast_in = 1'h0, cmd_pec_in = 1'h0;
   logic [1:0] cmd_nbytes_in = 2'h0;
   logic [2:0] addr_strap_in = 3'h5;
   logic [7:0] cmd_code_in = 8'h00;
   logic [15:0] cmd_wdata_in = 16'h0000, rd_val = 16'h0000;
   logic bad_pec = 1'h0, alarm = 1'h0, ot = 1'h0, flt = 1'h0;
   logic [19:0] stretch_ns = 20'h0;
   logic cmd_ready_out, done_out, nack_out, pec_err_out, timeout_out;
   logic scl_out, scl_oe_out, sda_out, sda_oe_out;
   logic alert_out, ot_warn_out, fault_out, d_scl_oe, d_sda_oe;
   logic alert_n, ot_warn_n, fault_n, pec_ok;
   logic [15:0] rd_data_out, wdata;
   logic [7:0] cmd_seen;
   logic [2:0] nbytes;
   wire scl_w, sda_w;
   int failures = 0, checks = 0, cyc = 0, lat = 0;
   time last_t = 0, per_ns = 0;
   // both lines pulled up, low while any party pulls
   assign scl_w = !((scl_oe_out && !scl_out) || d_scl_oe);
   assign sda_w = !((sda_oe_out && !sda_out) || d_sda_oe);
   // counts shortened so pacing and lock-up fit the run
   pmbh_host #(.ALERT_WAIT_CYC(26'h00000c8), .READ_GAP_CYC(26'h0000064),
      .LOCKUP_CYC(20'h007d0)) dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .cmd_valid_in(cmd_valid_in), .cmd_read_in(cmd_read_in),
      .cmd_fast_in(cmd_fast_in), .cmd_pec_in(cmd_pec_in),
      .cmd_nbytes_in(cmd_nbytes_in), .addr_strap_in(addr_strap_in),
      .cmd_code_in(cmd_code_in), .cmd_wdata_in(cmd_wdata_in),
      .cmd_ready_out(cmd_ready_out), .done_out(done_out),
      .rd_data_out(rd_data_out), .nack_out(nack_out),
      .pec_err_out(pec_err_out), .timeout_out(timeout_out),
      .scl_in(scl_w), .scl_out(scl_out), .scl_oe_out(scl_oe_out),
      .sda_in(sda_w), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
      .alert_n_in(alert_n), .ot_warn_n_in(ot_warn_n),
      .fault_n_in(fault_n), .alert_out(alert_out),
      .ot_warn_out(ot_warn_out), .fault_out(fault_out));
   pmbh_dev_model dev_u (.scl_in(scl_w), .sda_in(sda_w),
      .scl_oe_out(d_scl_oe), .sda_oe_out(d_sda_oe), .rd_val_in(rd_val),
      .bad_pec_in(bad_pec), .stretch_ns_in(stretch_ns), .alarm_in(alarm),
      .ot_in(ot), .fault_in(flt), .alert_n_out(alert_n),
      .ot_warn_n_out(ot_warn_n), .fault_n_out(fault_n),
      .cmd_out(cmd_seen), .wdata_out(wdata), .pec_ok_out(pec_ok),
      .nbytes_out(nbytes));
   always #20 clk_in = ~clk_in;
   // last spacing between rising bus clocks
   always @(posedge scl_w) begin
      per_ns = $time - last_t;
      last_t = $time;
   end
   // hang guard, well above the whole sequence
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 80000) begin
         failures++;
         test_done;
      end
   end
   task automatic check(input string name, input logic [15:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic test_done;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // one command; lat counts cycles from accept to the start condition
   task automatic run(input logic rd, fast, pec, input logic [1:0] nb,
         input logic [7:0] code, input logic [15:0] wd);
      int n;
      lat = -1;
      while (cmd_ready_out !== 1'h1) @(posedge clk_in);
      {cmd_valid_in, cmd_read_in} <= {1'h1, rd};
      {cmd_fast_in, cmd_pec_in} <= {fast, pec};
      {cmd_nbytes_in, cmd_code_in, cmd_wdata_in} <= {nb, code, wd};
      @(posedge clk_in);
      cmd_valid_in <= 1'h0;
      n = 0;
      while (done_out !== 1'h1 && n < 40000) begin
         @(posedge clk_in);
         n++;
         if (lat < 0 && sda_oe_out === 1'h1) lat = n;
      end
      check("done", done_out, 1'h1);
   endtask
   task automatic t_write;
      run(1'h0, 1'h0, 1'h1, 2'h2, 8'h21, 16'hbeef);
      check("cmd", cmd_seen, 8'h21);
      check("wdata", wdata, 16'hbeef);
      check("bytes", nbytes, 3'h5);
      check("pec_ok", pec_ok, 1'h1);
      check("slow", per_ns >= P_SLOW && per_ns <= P_SLOW + 400, 1'h1);
      run(1'h0, 1'h1, 1'h0, 2'h1, 8'h01, 16'h0080);
      check("nopec", nbytes, 3'h3);
      check("fast", per_ns >= P_FAST && per_ns <= P_FAST + 400, 1'h1);
   endtask
   task automatic t_read;
      rd_val <= 16'h1234;
      run(1'h1, 1'h1, 1'h1, 2'h2, 8'h8b, 16'h0000);
      check("rd_data", rd_data_out, 16'h1234);
      check("pec_err", pec_err_out, 1'h0);
      bad_pec <= 1'h1;
      run(1'h1, 1'h1, 1'h1, 2'h2, 8'h8b, 16'h0000);
      check("gap", lat >= 100, 1'h1);
      check("pec_bad", pec_err_out, 1'h1);
      bad_pec <= 1'h0;
      run(1'h1, 1'h1, 1'h0, 2'h2, 8'hee, 16'h0000);
      check("unsup", rd_data_out, 16'h0000);
      check("unsup_alert", alert_out, 1'h1);
      run(1'h0, 1'h1, 1'h0, 2'h0, 8'h03, 16'h0000);
      check("unsup_clr", alert_out, 1'h0);
      addr_strap_in <= 3'h3;
      run(1'h0, 1'h1, 1'h1, 2'h1, 8'h01, 16'h0000);
      check("nack", nack_out, 1'h1);
      addr_strap_in <= 3'h5;
   endtask
   task automatic t_stretch;
      stretch_ns <= 20'h01388;
      run(1'h0, 1'h1, 1'h1, 2'h3, 8'h21, 16'h5aa5);
      check("st_wd", wdata, 16'h5aa5);
      check("clamp", nbytes, 3'h5);
      check("st_to", timeout_out, 1'h0);
      stretch_ns <= 20'h186a0;
      run(1'h0, 1'h1, 1'h1, 2'h2, 8'h21, 16'h0000);
      @(posedge clk_in);
      check("lockup", timeout_out, 1'h1);
      check("freed", {scl_oe_out, sda_oe_out}, 2'h0);
      stretch_ns <= 20'h0;
      repeat (3000) @(posedge clk_in);
   endtask
   task automatic t_alert;
      alarm <= 1'h1;
      repeat (8) @(posedge clk_in);
      check("alert_on", alert_out, 1'h1);
      run(1'h1, 1'h1, 1'h0, 2'h0, 8'h79, 16'h0000);
      check("alert_wait", lat + 9 >= 200, 1'h1);
      run(1'h0, 1'h1, 1'h0, 2'h0, 8'h03, 16'h0000);
      repeat (8) @(posedge clk_in);
      check("alert_kept", alert_out, 1'h1);
      alarm <= 1'h0;
      run(1'h0, 1'h1, 1'h0, 2'h0, 8'h03, 16'h0000);
      repeat (8) @(posedge clk_in);
      check("alert_clr", alert_out, 1'h0);
      {ot, flt} <= 2'h3;
      repeat (8) @(posedge clk_in);
      check("ot_fault", {ot_warn_out, fault_out}, 2'h3);
   endtask
   initial begin
      repeat (2) @(posedge clk_in);
      rst_n_in <= 1'h1;
      t_write;
      t_read;
      t_stretch;
      t_alert;
      test_done;
   end
endmodule
